// [fdcr_defs.vh]
/*
 * constants for the floppy configuration register bank:
 * register indices, field positions, reset values, bus answers.
 * assumes: included by fdcr_top.v only; definitions only.
 */
`ifndef FDCR_DEFS_VH
`define FDCR_DEFS_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define FDCR_IDX_MODE 10'h0F0
`define FDCR_IDX_OPTION 10'h0F1
`define FDCR_IDX_DTYPE 10'h0F2
`define FDCR_IDX_RSVD_F3 10'h0F3
`define FDCR_IDX_DRV0 10'h0F4
`define FDCR_IDX_RSVD_F5 10'h0F5
`define FDCR_IDX_EXT_CTRL 10'h0F8
`define FDCR_IDX_STATUS 10'h0F9

// ----------------------------------------
// decoded register selects
// ----------------------------------------
`define FDCR_SEL_NONE 4'h0
`define FDCR_SEL_MODE 4'h1
`define FDCR_SEL_OPTION 4'h2
`define FDCR_SEL_DTYPE 4'h3
`define FDCR_SEL_RSVD 4'h4
`define FDCR_SEL_DRV0 4'h5
`define FDCR_SEL_EXT_CTRL 4'h6
`define FDCR_SEL_STATUS 4'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define FDCR_MODE_RST 8'h0E
`define FDCR_OPTION_RST 8'h00
`define FDCR_DTYPE_RST 8'hFF
`define FDCR_DRV0_RST 8'h00
`define FDCR_EXT_CTRL_RST 8'h00
`define FDCR_SYNC_RST 3'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define FDCR_MODE_ENH 0
`define FDCR_MODE_NONBURST 1
`define FDCR_MODE_IF_HI 3
`define FDCR_MODE_IF_LO 2
`define FDCR_MODE_PUSH_PULL 6
`define FDCR_MODE_TRISTATE 7
`define FDCR_OPT_FORCE_WP 0
`define FDCR_OPT_DENS_HI 3
`define FDCR_OPT_DENS_LO 2
`define FDCR_DRV0_DT_HI 1
`define FDCR_DRV0_DT_LO 0
`define FDCR_DRV0_RATE 3
`define FDCR_DRV0_PRECOMP_DIS 6
`define FDCR_EXT_WP_FORCE 0

// ----------------------------------------
// field encodings and masks
// ----------------------------------------
`define FDCR_IF_AT 2'h3
`define FDCR_IF_LEGACY2 2'h1
`define FDCR_IF_LEGACY3 2'h0
`define FDCR_DENS_FORCE_ONE 2'h2
`define FDCR_DENS_FORCE_ZERO 2'h3
`define FDCR_DRV0_WMASK 8'h5B
`define FDCR_EXT_WMASK 8'h01
`define FDCR_BOOT_DRIVE 2'h0

// ----------------------------------------
// bus answers
// ----------------------------------------
`define FDCR_RESP_OKAY 2'h0
`define FDCR_RESP_SLVERR 2'h2
`define FDCR_ZERO32 32'h00000000

`endif

// [fdcr_top.v]
/*
 * floppy controller configuration register bank with an axi4-lite slave.
 * assumes: one clock, async active-low reset (the super-i/o domain reset),
 * drive-side pins arrive asynchronously, core signals share the clock.
 */
`timescale 1ns/1ps
`include "fdcr_defs.vh"

module fdcr_top #(
	parameter NUM_PINS = 8,
	parameter ADDR_W = 12
) (
	input wire clk_sys_i,
	input wire resetn_i,
	input wire [ADDR_W-1:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	output wire [1:0] s_axi_bresp_o,
	output wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [ADDR_W-1:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0] s_axi_rresp_o,
	output wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	input wire write_protect_pin_n_i,
	input wire drive0_select_n_i,
	input wire drive1_select_n_i,
	input wire density_core_i,
	input wire [NUM_PINS-1:0] core_pin_val_i,
	output wire core_enhanced_mode_o,
	output wire core_nonburst_dma_o,
	output wire core_at_mode_o,
	output wire core_legacy2_mode_o,
	output wire core_legacy3_mode_o,
	output wire core_write_protect_n_o,
	output wire status_register_a_wp_o,
	output wire density_o,
	output wire [1:0] drive_type_bits_o,
	output wire rate_table_select_o,
	output wire precomp_disable_o,
	output wire [1:0] boot_drive_o,
	output wire [NUM_PINS-1:0] fdc_pin_o,
	output wire [NUM_PINS-1:0] fdc_pin_oe_o
);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function [3:0] reg_sel;
		input [ADDR_W-1:0] addr;
		begin
			case (addr[ADDR_W-1:2])
				`FDCR_IDX_MODE: reg_sel = `FDCR_SEL_MODE;
				`FDCR_IDX_OPTION: reg_sel = `FDCR_SEL_OPTION;
				`FDCR_IDX_DTYPE: reg_sel = `FDCR_SEL_DTYPE;
				`FDCR_IDX_RSVD_F3: reg_sel = `FDCR_SEL_RSVD;
				`FDCR_IDX_DRV0: reg_sel = `FDCR_SEL_DRV0;
				`FDCR_IDX_RSVD_F5: reg_sel = `FDCR_SEL_RSVD;
				`FDCR_IDX_EXT_CTRL: reg_sel = `FDCR_SEL_EXT_CTRL;
				`FDCR_IDX_STATUS: reg_sel = `FDCR_SEL_STATUS;
				default: reg_sel = `FDCR_SEL_NONE;
			endcase
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [7:0] mode_q;
	reg [7:0] option_q;
	reg [7:0] dtype_q;
	reg [7:0] drv0_q;
	reg [7:0] ext_ctrl_q;
	reg [2:0] sync1_q;
	reg [2:0] sync2_q;
	reg aw_full_q;
	reg w_full_q;
	reg [ADDR_W-1:0] awaddr_q;
	reg [7:0] wdata_q;
	reg wstrb0_q;
	reg awready_q;
	reg wready_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg arready_q;
	reg rvalid_q;
	reg [1:0] rresp_q;
	reg [31:0] rdata_q;
	reg enh_q;
	reg nonburst_q;
	reg at_q;
	reg leg2_q;
	reg leg3_q;
	reg core_wp_n_q;
	reg sra_wp_q;
	reg density_q;
	reg [1:0] dt_q;
	reg rate_q;
	reg precomp_dis_q;
	reg [1:0] boot_q;
	reg [NUM_PINS-1:0] pin_q;
	reg [NUM_PINS-1:0] pin_oe_q;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_q <= `FDCR_SYNC_RST;
			sync2_q <= `FDCR_SYNC_RST;
		end else begin
			sync1_q <= {drive1_select_n_i, drive0_select_n_i, write_protect_pin_n_i};
			sync2_q <= sync1_q;
		end
	end

	wire wp_pin_act = ~sync2_q[0];
	wire ds0_act = ~sync2_q[1];
	wire ds1_act = ~sync2_q[2];

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	wire aw_take = s_axi_awvalid_i & awready_q;
	wire w_take = s_axi_wvalid_i & wready_q;
	wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
	wire [3:0] wsel = reg_sel(awaddr_q);
	wire wr_en = wr_go & wstrb0_q;

	reg aw_full_d;
	reg w_full_d;
	reg bvalid_d;

	always @* begin
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		bvalid_d = bvalid_q;
		if (aw_take) begin
			aw_full_d = 1'b1;
		end
		if (w_take) begin
			w_full_d = 1'b1;
		end
		if (wr_go) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
		end else if (bvalid_q & s_axi_bready_i) begin
			bvalid_d = 1'b0;
		end
	end

	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `FDCR_RESP_OKAY;
			awaddr_q <= {ADDR_W{1'b0}};
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready_q <= ~aw_full_d & ~bvalid_d;
			wready_q <= ~w_full_d & ~bvalid_d;
			bvalid_q <= bvalid_d;
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr_i;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata_i[7:0];
				wstrb0_q <= s_axi_wstrb_i[0];
			end
			if (wr_go) begin
				bresp_q <= (wsel == `FDCR_SEL_NONE) ? `FDCR_RESP_SLVERR : `FDCR_RESP_OKAY;
			end
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_q <= `FDCR_MODE_RST;
			option_q <= `FDCR_OPTION_RST;
			dtype_q <= `FDCR_DTYPE_RST;
			drv0_q <= `FDCR_DRV0_RST;
			ext_ctrl_q <= `FDCR_EXT_CTRL_RST;
		end else if (wr_en) begin
			case (wsel)
				`FDCR_SEL_MODE: mode_q <= wdata_q;
				`FDCR_SEL_OPTION: option_q <= wdata_q;
				`FDCR_SEL_DTYPE: dtype_q <= wdata_q;
				`FDCR_SEL_DRV0: drv0_q <= wdata_q & `FDCR_DRV0_WMASK;
				`FDCR_SEL_EXT_CTRL: ext_ctrl_q <= wdata_q & `FDCR_EXT_WMASK;
				default: ext_ctrl_q <= ext_ctrl_q;
			endcase
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	wire ar_take = s_axi_arvalid_i & arready_q;
	wire [3:0] rsel = reg_sel(s_axi_araddr_i);
	wire [7:0] status_byte = {3'h0, wp_pin_act, ds1_act, ds0_act, density_q, ~core_wp_n_q};

	reg [7:0] rbyte;

	always @* begin
		case (rsel)
			`FDCR_SEL_MODE: rbyte = mode_q;
			`FDCR_SEL_OPTION: rbyte = option_q;
			`FDCR_SEL_DTYPE: rbyte = dtype_q;
			`FDCR_SEL_DRV0: rbyte = drv0_q & `FDCR_DRV0_WMASK;
			`FDCR_SEL_EXT_CTRL: rbyte = ext_ctrl_q;
			`FDCR_SEL_STATUS: rbyte = status_byte;
			default: rbyte = 8'h00;
		endcase
	end

	reg rvalid_d;

	always @* begin
		rvalid_d = rvalid_q;
		if (ar_take) begin
			rvalid_d = 1'b1;
		end else if (rvalid_q & s_axi_rready_i) begin
			rvalid_d = 1'b0;
		end
	end

	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= `FDCR_RESP_OKAY;
			rdata_q <= `FDCR_ZERO32;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q <= rvalid_d;
			if (ar_take) begin
				rdata_q <= {24'h000000, rbyte};
				rresp_q <= (rsel == `FDCR_SEL_NONE) ? `FDCR_RESP_SLVERR : `FDCR_RESP_OKAY;
			end
		end
	end

	// ----------------------------------------
	// core steering
	// ----------------------------------------
	wire [1:0] if_mode = mode_q[`FDCR_MODE_IF_HI:`FDCR_MODE_IF_LO];
	wire [1:0] dens_sel = option_q[`FDCR_OPT_DENS_HI:`FDCR_OPT_DENS_LO];
	wire force_wp = option_q[`FDCR_OPT_FORCE_WP];
	wire wp_active = ((ds0_act | ds1_act) & force_wp) | wp_pin_act |
		ext_ctrl_q[`FDCR_EXT_WP_FORCE];

	reg density_d;

	always @* begin
		case (dens_sel)
			`FDCR_DENS_FORCE_ONE: density_d = 1'b1;
			`FDCR_DENS_FORCE_ZERO: density_d = 1'b0;
			default: density_d = density_core_i;
		endcase
	end

	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			enh_q <= 1'b0;
			nonburst_q <= 1'b1;
			at_q <= 1'b1;
			leg2_q <= 1'b0;
			leg3_q <= 1'b0;
			core_wp_n_q <= 1'b1;
			sra_wp_q <= 1'b0;
			density_q <= 1'b0;
			dt_q <= 2'h0;
			rate_q <= 1'b0;
			precomp_dis_q <= 1'b0;
			boot_q <= `FDCR_BOOT_DRIVE;
		end else begin
			enh_q <= mode_q[`FDCR_MODE_ENH];
			nonburst_q <= mode_q[`FDCR_MODE_NONBURST];
			at_q <= (if_mode == `FDCR_IF_AT);
			leg2_q <= (if_mode == `FDCR_IF_LEGACY2);
			leg3_q <= (if_mode == `FDCR_IF_LEGACY3);
			core_wp_n_q <= ~wp_active;
			sra_wp_q <= wp_active;
			density_q <= density_d;
			dt_q <= drv0_q[`FDCR_DRV0_DT_HI:`FDCR_DRV0_DT_LO];
			rate_q <= drv0_q[`FDCR_DRV0_RATE];
			precomp_dis_q <= drv0_q[`FDCR_DRV0_PRECOMP_DIS];
			boot_q <= `FDCR_BOOT_DRIVE;
		end
	end

	// ----------------------------------------
	// floppy output pin drivers
	// ----------------------------------------
	wire push_pull = mode_q[`FDCR_MODE_PUSH_PULL];
	wire tristate = mode_q[`FDCR_MODE_TRISTATE];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
			always @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i) begin
					pin_q[gi] <= 1'b0;
					pin_oe_q[gi] <= 1'b0;
				end else begin
					pin_q[gi] <= push_pull & core_pin_val_i[gi];
					pin_oe_q[gi] <= ~tristate & (push_pull | ~core_pin_val_i[gi]);
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o = wready_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rresp_o = rresp_q;
	assign s_axi_rdata_o = rdata_q;
	assign core_enhanced_mode_o = enh_q;
	assign core_nonburst_dma_o = nonburst_q;
	assign core_at_mode_o = at_q;
	assign core_legacy2_mode_o = leg2_q;
	assign core_legacy3_mode_o = leg3_q;
	assign core_write_protect_n_o = core_wp_n_q;
	assign status_register_a_wp_o = sra_wp_q;
	assign density_o = density_q;
	assign drive_type_bits_o = dt_q;
	assign rate_table_select_o = rate_q;
	assign precomp_disable_o = precomp_dis_q;
	assign boot_drive_o = boot_q;
	assign fdc_pin_o = pin_q;
	assign fdc_pin_oe_o = pin_oe_q;

endmodule

// [fdcr_fdd_model.sv]
/*
 * model of the floppy core and drive cable around the config bank.
 * assumes: the bench calls set() just after a rising clock edge.
 */
`timescale 1ns/1ps
module fdcr_fdd_model (
	output logic wp_pin_n_o,
	output logic sel0_n_o,
	output logic sel1_n_o,
	output logic dens_o,
	output logic [7:0] pin_val_o
);
	// ----------------------------------------
	// pin levels, idle cable at start
	// ----------------------------------------
	initial begin
		wp_pin_n_o = 1'b1;
		sel0_n_o = 1'b1;
		sel1_n_o = 1'b1;
		dens_o = 1'b0;
		pin_val_o = 8'hA5;
	end
	task set(input logic wp_n, input logic s0_n, input logic s1_n, input logic dn,
		input logic [7:0] pv);
		wp_pin_n_o <= wp_n;
		sel0_n_o <= s0_n;
		sel1_n_o <= s1_n;
		dens_o <= dn;
		pin_val_o <= pv;
	endtask
endmodule

// [fdcr_top_sva.sv]
/*
 * port checker for the floppy config bank.
 * assumes: bound into fdcr_top; one clock, active-low async reset.
 */
`timescale 1ns/1ps
module fdcr_top_sva #(
	parameter NUM_PINS = 8,
	parameter ADDR_W = 12
) (
	input wire clk_sys_i,
	input wire resetn_i,
	input wire s_axi_awvalid_i,
	input wire s_axi_awready_o,
	input wire s_axi_wvalid_i,
	input wire s_axi_wready_o,
	input wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [1:0] s_axi_bresp_o,
	input wire s_axi_arvalid_i,
	input wire s_axi_arready_o,
	input wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	input wire [31:0] s_axi_rdata_o,
	input wire write_protect_pin_n_i,
	input wire [NUM_PINS-1:0] core_pin_val_i,
	input wire core_at_mode_o,
	input wire core_legacy2_mode_o,
	input wire core_legacy3_mode_o,
	input wire core_write_protect_n_o,
	input wire status_register_a_wp_o,
	input wire [1:0] boot_drive_o,
	input wire [NUM_PINS-1:0] fdc_pin_o,
	input wire [NUM_PINS-1:0] fdc_pin_oe_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// ----------------------------------------
	// sequences and properties
	// ----------------------------------------
	sequence s_wtake;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_wp_low;
		!write_protect_pin_n_i [*4];
	endsequence
	property p_wlat; s_wtake |-> ##2 s_axi_bvalid_o; endproperty
	a_wlat: assert property (p_wlat) else $error("write answer not on time");
	property p_rlat; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
	a_rlat: assert property (p_rlat) else $error("read answer not on time");
	property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_rbusy; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
	a_rbusy: assert property (p_rbusy) else $error("read taken while busy");
	property p_pins; $past(resetn_i) |-> fdc_pin_oe_o == 0 || (fdc_pin_o == 0 &&
		fdc_pin_oe_o == ~$past(core_pin_val_i)) || (&fdc_pin_oe_o && fdc_pin_o == $past(core_pin_val_i));
	endproperty
	a_pins: assert property (p_pins) else $error("pin drive wrong");
	property p_wp; s_wp_low |-> !core_write_protect_n_o; endproperty
	a_wp: assert property (p_wp) else $error("pin protect not passed");
	property p_sra; status_register_a_wp_o == !core_write_protect_n_o; endproperty
	a_sra: assert property (p_sra) else $error("status protect mismatch");
	property p_iface; $onehot0({core_at_mode_o, core_legacy2_mode_o, core_legacy3_mode_o}); endproperty
	a_iface: assert property (p_iface) else $error("two personalities");
	property p_boot; boot_drive_o == 2'h0; endproperty
	a_boot: assert property (p_boot) else $error("boot drive not zero");
endmodule
bind fdcr_top fdcr_top_sva #(.NUM_PINS(NUM_PINS), .ADDR_W(ADDR_W)) u_sva (.*);

// [floppy_config_registers_test.sv]
/*
 * self-checking bench for the floppy config bank.
 * assumes: checker bound by its own file; core model drives cable pins.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module floppy_config_registers_test;
	logic clk_sys_i = 1'b0, resetn_i = 1'b0;
	logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
	logic [31:0] s_axi_wdata_i = 32'h00000000;
	logic [3:0] s_axi_wstrb_i = 4'hF;
	logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
	logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
	wire write_protect_pin_n_i, drive0_select_n_i, drive1_select_n_i, density_core_i;
	wire [7:0] core_pin_val_i, fdc_pin_o, fdc_pin_oe_o;
	wire [31:0] s_axi_rdata_o;
	wire [1:0] s_axi_bresp_o, s_axi_rresp_o, drive_type_bits_o, boot_drive_o;
	wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	wire core_enhanced_mode_o, core_nonburst_dma_o, core_at_mode_o;
	wire core_legacy2_mode_o, core_legacy3_mode_o, core_write_protect_n_o;
	wire status_register_a_wp_o, density_o, rate_table_select_o, precomp_disable_o;
	int n_mismatch = 0, n_checks = 0, i;
	logic [33:0] exp_q[$];
	logic [33:0] exp_v;
	logic [7:0] d;
	logic [7:0] rv[6] = '{8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
	logic [7:0] pm[3] = '{8'h0E, 8'h4E, 8'h8E};
	logic [7:0] pv[3] = '{8'h00, 8'hA5, 8'h00};
	logic [7:0] po[3] = '{8'h5A, 8'hFF, 8'h00};
	logic [4:0] wt[5] = '{5'b10100, 5'b10111, 5'b00010, 5'b01110, 5'b00101};
	always #2.5 clk_sys_i = ~clk_sys_i;
	fdcr_top uut (.*);
	fdcr_fdd_model core (.wp_pin_n_o(write_protect_pin_n_i), .sel0_n_o(drive0_select_n_i),
		.sel1_n_o(drive1_select_n_i), .dens_o(density_core_i), .pin_val_o(core_pin_val_i));
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task rst;
		resetn_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		@(posedge clk_sys_i);
	endtask
	task wr(input logic [9:0] idx, input logic [7:0] dv, input logic [1:0] r);
		s_axi_awaddr_i <= {idx, 2'b00};
		s_axi_wdata_i <= {24'h000000, dv};
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		exp_q.push_back({r, 32'h00000000});
		do begin
			@(posedge clk_sys_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b1;
		@(posedge clk_sys_i);
		s_axi_bready_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] r);
		s_axi_araddr_i <= {idx, 2'b00};
		s_axi_arvalid_i <= 1'b1;
		exp_q.push_back({r, 24'h000000, e});
		do begin
			@(posedge clk_sys_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'b1;
		@(posedge clk_sys_i);
		s_axi_rready_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------------------------------
	// answer monitor
	// ----------------------------------------
	always @(posedge clk_sys_i) begin
		if ((s_axi_bvalid_o && s_axi_bready_i) || (s_axi_rvalid_o && s_axi_rready_i)) begin
			exp_v = exp_q.pop_front();
			if (s_axi_bvalid_o) `CHK(s_axi_bresp_o, exp_v[33:32])
			else `CHK({s_axi_rresp_o, s_axi_rdata_o}, exp_v)
		end
	end
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(10));
		rst();
		for (i = 0; i < 6; i++) rd(10'h0F0 + 10'(i), rv[i], 2'h0);
		`CHK({core_enhanced_mode_o, core_nonburst_dma_o, core_at_mode_o}, 3'h3)
		rd(10'h010, 8'h00, 2'h2);
		wr(10'h010, 8'h55, 2'h2);
		d = 8'($urandom);
		wr(10'h0F2, d, 2'h0);
		rd(10'h0F2, d, 2'h0);
		s_axi_wstrb_i <= 4'h0;
		wr(10'h0F2, ~d, 2'h0);
		s_axi_wstrb_i <= 4'hF;
		rd(10'h0F2, d, 2'h0);
		wr(10'h0F3, 8'hFF, 2'h0);
		rd(10'h0F3, 8'h00, 2'h0);
		d = 8'($urandom) & 8'hEF;
		wr(10'h0F4, d, 2'h0);
		rd(10'h0F4, d & 8'h5B, 2'h0);
		`CHK({precomp_disable_o, rate_table_select_o}, {d[6], d[3]})
		`CHK(drive_type_bits_o, d[1:0])
		for (i = 0; i < 4; i++) begin
			d = {3'h0, 1'($urandom), i[1:0], 2'($urandom)};
			wr(10'h0F0, d, 2'h0);
			rd(10'h0F0, d, 2'h0);
			`CHK({core_nonburst_dma_o, core_enhanced_mode_o}, d[1:0])
			`CHK({core_at_mode_o, core_legacy2_mode_o, core_legacy3_mode_o}, {i == 3, i == 1, !i})
		end
		for (i = 0; i < 3; i++) begin
			wr(10'h0F0, pm[i], 2'h0);
			`CHK(fdc_pin_oe_o, po[i])
			`CHK(fdc_pin_o & fdc_pin_oe_o, pv[i])
		end
		for (i = 0; i < 8; i++) begin
			core.set(1'b1, 1'b1, 1'b1, i[2], 8'hA5);
			wr(10'h0F1, {4'h0, i[1:0], 2'h0}, 2'h0);
			`CHK(density_o, (i[1:0] == 2) ? 1'b1 : (i[1:0] == 3) ? 1'b0 : i[2])
		end
		for (i = 0; i < 5; i++) begin
			wr(10'h0F1, {7'h00, wt[i][4]}, 2'h0);
			wr(10'h0F8, {7'h00, wt[i][3]}, 2'h0);
			core.set(wt[i][2], wt[i][1], 1'b1, 1'b0, 8'hA5);
			repeat (4) @(posedge clk_sys_i);
			`CHK({core_write_protect_n_o, status_register_a_wp_o}, {wt[i][0], ~wt[i][0]})
			rd(10'h0F8, {7'h00, wt[i][3]}, 2'h0);
			rd(10'h0F9, {3'h0, ~wt[i][2], 1'b0, ~wt[i][1], 1'b0, ~wt[i][0]}, 2'h0);
		end
		wr(10'h0F1, 8'h01, 2'h0);
		core.set(1'b1, 1'b1, 1'b0, 1'b0, 8'hA5);
		repeat (4) @(posedge clk_sys_i);
		`CHK({core_write_protect_n_o, status_register_a_wp_o}, 2'h1)
		rd(10'h0F9, 8'h09, 2'h0);
		`CHK(boot_drive_o, 2'h0)
		wr(10'h0F2, 8'h12, 2'h0);
		rst();
		rd(10'h0F2, 8'hFF, 2'h0);
		rd(10'h0F0, 8'h0E, 2'h0);
		wrap_up();
	end
endmodule
